// ---- verilog/adc_mode_clock_config.sv ----
/*
  Mode and clock configuration registers with the data-ready pin driver
  and the reset-occurred and input check error status flags.
  Assumes the serial framing logic on the same clock presents whole
  register words on a simple index/strobe port and reports check failures
  and data reads as one-cycle pulses; converter events arrive likewise.
*/
`timescale 1ns/100ps
`default_nettype none

module adc_mode_clock_config (
  input  wire logic        sys_clk,                 // System clock, 125 MHz
  input  wire logic        rst,                     // Synchronous reset, active high
  input  wire logic [5:0]  reg_index,               // Register index from framing logic
  input  wire logic        reg_write,               // One-cycle write strobe
  input  wire logic [15:0] reg_write_data,          // Word to write
  output logic      [15:0] reg_read_data,           // Registered read word
  input  wire logic        rx_check_fail,           // Pulse: incoming word failed its check
  input  wire logic        status_read,             // Pulse: status word was sent to host
  input  wire logic [3:0]  chan_new_data,           // Pulse per channel: conversion done
  input  wire logic        data_frame_read,         // Pulse: conversion data read out
  output logic             regmap_check_enable,     // Register map check on
  output logic             rx_check_enable,         // Incoming word check on
  output logic             check_poly_ansi,         // 1 = ANSI polynomial, 0 = CCITT
  output logic      [1:0]  word_length_select,      // Output word length code
  output logic             frame_timeout_enable,    // Serial frame timeout on
  output logic      [1:0]  ready_source_select,     // Ready pin source code
  output logic             ready_idle_float,        // Float the pin when idle
  output logic             ready_pulse_format,      // Pulse instead of level
  output logic             chan0_conv_enable,       // Channel 0 converter on
  output logic             chan1_conv_enable,       // Channel 1 converter on
  output logic             chan2_conv_enable,       // Channel 2 converter on
  output logic             chan3_conv_enable,       // Channel 3 converter on
  output logic             ratio64_override,        // Ratio forced to 64
  output logic      [2:0]  oversample_ratio_select, // Ratio field
  output logic      [14:0] oversample_ratio,        // Effective ratio value
  output logic      [1:0]  power_mode_select,       // Power mode field
  output logic             power_very_low,          // Very-low-power decoded
  output logic             power_low,               // Low-power decoded
  output logic             status_reset_flag,       // Reset occurred, not acknowledged
  output logic             status_check_error,      // Input check error seen
  output logic      [3:0]  chan_pending,            // Per-channel data pending
  output logic             data_ready_pin_out,      // Ready pin level
  output logic             data_ready_pin_oe        // Ready pin drive enable
);

  // Stored register words, status state and internal decodes
  logic [15:0]                    mode_word;        // Mode register contents
  logic [15:0]                    clock_word;       // Clock register contents
  logic                           reset_flag;       // Reset-occurred flag
  logic                           check_error;      // Sticky input check error
  logic [3:0]                     pending;          // Channels with unread data
  logic                           leading_latch;    // First channel seen this cycle of data
  logic                           ready_active;     // Selected ready condition
  logic                           ready_active_d;   // Previous ready condition
  adc_cfg_pkg::pin_phase_type     phase;            // Pin drive phase
  adc_cfg_pkg::pin_phase_type     next_phase;       // Next pin drive phase
  logic [3:0]                     pulse_count;      // Cycles left in the low pulse
  logic [3:0]                     enables;          // Channel enables as a vector
  logic                           mode_hit;         // Write addressed to mode
  logic                           clock_hit;        // Write addressed to clock

  // Maps the ratio code to its oversampling value
  function automatic logic [14:0] ratio_value(input logic [2:0] code);
    logic [14:0] v;
    v = 15'h0080;
    unique case (code)
      3'h0: v = 15'h0080;                           // 128
      3'h1: v = 15'h0100;                           // 256
      3'h2: v = 15'h0200;                           // 512
      3'h3: v = 15'h0400;                           // 1024
      3'h4: v = 15'h0800;                           // 2048
      3'h5: v = 15'h1000;                           // 4096
      3'h6: v = 15'h2000;                           // 8192
      3'h7: v = 15'h3f80;                           // 16256, not a power of two
    endcase
    return v;
  endfunction

  // Write decode; a write to any other index is dropped
  assign mode_hit  = reg_write && (reg_index == adc_cfg_pkg::MODE_INDEX);
  assign clock_hit = reg_write && (reg_index == adc_cfg_pkg::CLOCK_INDEX);

  // Mode register; reserved bits are stored as written so that read-back
  // matches, the host is expected to keep them zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_word <= adc_cfg_pkg::MODE_RESET;
    end else if (mode_hit) begin
      mode_word <= reg_write_data;
    end
  end

  // Reset-occurred flag: only a device reset sets it, a write of 0 clears
  // it; writing 1 leaves it as it is
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_flag <= 1'b1;
    end else if (mode_hit && !reg_write_data[adc_cfg_pkg::MODE_RESET_FLAG]) begin
      reset_flag <= 1'b0;
    end
  end

  // Clock register; top nibble never stores anything
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_word <= adc_cfg_pkg::CLOCK_RESET;
    end else if (clock_hit) begin
      clock_word <= reg_write_data & adc_cfg_pkg::CLOCK_WRITE_MASK;
    end
  end

  // Sticky input check error; a failure in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      check_error <= 1'b0;
    end else if (rx_check_fail && rx_check_enable) begin
      check_error <= 1'b1;
    end else if (status_read) begin
      check_error <= 1'b0;
    end
  end

  // Read mux; unmapped indexes read zero
  // Bit 10 shows the live reset flag rather than the stored bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_read_data <= 16'h0000;
    end else if (reg_index == adc_cfg_pkg::MODE_INDEX) begin
      reg_read_data <= {mode_word[15:11], reset_flag, mode_word[9:0]};
    end else if (reg_index == adc_cfg_pkg::CLOCK_INDEX) begin
      reg_read_data <= clock_word;
    end else begin
      reg_read_data <= 16'h0000;
    end
  end

  // Field outputs straight from the stored words
  assign regmap_check_enable     = mode_word[adc_cfg_pkg::MODE_REGMAP_CHECK];
  assign rx_check_enable         = mode_word[adc_cfg_pkg::MODE_INPUT_CHECK];
  assign check_poly_ansi         = mode_word[adc_cfg_pkg::MODE_CHECK_POLY];
  assign word_length_select      = mode_word[adc_cfg_pkg::MODE_WLEN_HI:adc_cfg_pkg::MODE_WLEN_LO];
  assign frame_timeout_enable    = mode_word[adc_cfg_pkg::MODE_TIMEOUT];
  assign ready_source_select     = mode_word[adc_cfg_pkg::MODE_RSRC_HI:adc_cfg_pkg::MODE_RSRC_LO];
  assign ready_idle_float        = mode_word[adc_cfg_pkg::MODE_IDLE_FLOAT];
  assign ready_pulse_format      = mode_word[adc_cfg_pkg::MODE_PULSE_FMT];
  assign enables                 = clock_word[adc_cfg_pkg::CLOCK_CHAN_HI:adc_cfg_pkg::CLOCK_CHAN_LO];
  assign chan0_conv_enable       = enables[0];
  assign chan1_conv_enable       = enables[1];
  assign chan2_conv_enable       = enables[2];
  assign chan3_conv_enable       = enables[3];
  assign ratio64_override        = clock_word[adc_cfg_pkg::CLOCK_RATIO64];
  assign oversample_ratio_select = clock_word[adc_cfg_pkg::CLOCK_RATIO_HI:adc_cfg_pkg::CLOCK_RATIO_LO];
  assign power_mode_select       = clock_word[adc_cfg_pkg::CLOCK_POWER_HI:adc_cfg_pkg::CLOCK_POWER_LO];
  assign status_reset_flag       = reset_flag;
  assign status_check_error      = check_error;
  assign chan_pending            = pending;

  // Effective ratio: the override beats the field
  // Registered so that a write gives one clean step at the modulators
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oversample_ratio <= ratio_value(adc_cfg_pkg::CLOCK_RESET[4:2]);
    end else if (ratio64_override) begin
      oversample_ratio <= adc_cfg_pkg::RATIO_FORCED;
    end else begin
      oversample_ratio <= ratio_value(oversample_ratio_select);
    end
  end

  // Power mode decodes, registered like the effective ratio; they
  // trail the field by one edge, which nothing downstream depends on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_very_low <= 1'b0;                       // High-resolution after reset
      power_low      <= 1'b0;
    end else begin
      power_very_low <= (power_mode_select == adc_cfg_pkg::POWER_VERY_LOW);
      power_low      <= (power_mode_select == adc_cfg_pkg::POWER_LOW);
    end
  end

  // Per-channel pending data; disabled channels never go pending and a
  // new conversion in the read cycle is kept
  // Limitation: disabling a channel drops its unread data at once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= 4'h0;
    end else begin
      pending <= ((data_frame_read ? 4'h0 : pending) | chan_new_data) & enables;
    end
  end

  // Leading source holds from the first enabled arrival until the readout
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      leading_latch <= 1'b0;
    end else if (|(chan_new_data & enables)) begin
      leading_latch <= 1'b1;
    end else if (data_frame_read) begin
      leading_latch <= 1'b0;
    end
  end

  // Source choice; with no channel enabled the pin stays idle
  // Codes 2 and 3 both take the leading latch
  always_comb begin
    ready_active = 1'b0;
    if (enables != 4'h0) begin
      if (ready_source_select == adc_cfg_pkg::RSRC_LAGGING) begin
        ready_active = ((pending & enables) == enables);
      end else if (ready_source_select == adc_cfg_pkg::RSRC_ANY) begin
        ready_active = |(pending & enables);
      end else begin
        ready_active = leading_latch;
      end
    end
  end

  // Edge memory of the ready condition for the pulse format
  // Only a fresh rise of the condition starts a new low phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_active_d <= 1'b0;
    end else begin
      ready_active_d <= ready_active;
    end
  end

  // Pin phase choice
  always_comb begin
    next_phase = phase;
    unique case (phase)
      adc_cfg_pkg::PIN_IDLE: begin
        if (ready_active && !ready_active_d) begin
          next_phase = ready_pulse_format ? adc_cfg_pkg::PIN_LOW_PULSE
                                          : adc_cfg_pkg::PIN_LOW_LEVEL;
        end
      end
      adc_cfg_pkg::PIN_LOW_LEVEL: begin
        if (!ready_active) begin
          next_phase = adc_cfg_pkg::PIN_IDLE;
        end
      end
      adc_cfg_pkg::PIN_LOW_PULSE: begin
        if (pulse_count == 4'h1) begin
          next_phase = adc_cfg_pkg::PIN_IDLE;
        end
      end
      default: begin
        next_phase = adc_cfg_pkg::PIN_IDLE;
      end
    endcase
  end

  // Phase register
  // The unused encoding is left through the default branch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= adc_cfg_pkg::PIN_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Pulse length counter, loaded as the pulse starts; the pulse runs to
  // its end even if the data are read early, so its width stays fixed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_count <= 4'h0;
    end else if (phase == adc_cfg_pkg::PIN_IDLE) begin
      pulse_count <= adc_cfg_pkg::READY_PULSE_LEN;
    end else if (pulse_count != 4'h0) begin
      pulse_count <= pulse_count - 4'h1;
    end
  end

  // Pin drive, registered: low while data show, else high or floating
  // It looks at next_phase so the pin moves on the same edge as the phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_ready_pin_out <= 1'b1;
      data_ready_pin_oe  <= 1'b1;
    end else if (next_phase != adc_cfg_pkg::PIN_IDLE) begin
      data_ready_pin_out <= 1'b0;
      data_ready_pin_oe  <= 1'b1;
    end else begin
      data_ready_pin_out <= 1'b1;
      data_ready_pin_oe  <= !ready_idle_float;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/adc_cfg_pkg.sv ----
/*
  Constants for the mode and clock configuration registers of a
  four-channel delta-sigma converter: register indexes, field positions,
  reset values, encodings and the ready pulse length.
  Assumes a single 125 MHz system clock shared with the serial framing logic.
*/
`default_nettype none

package adc_cfg_pkg;

  // Register indexes on the internal word port
  localparam logic [5:0]  MODE_INDEX        = 6'h02;
  localparam logic [5:0]  CLOCK_INDEX       = 6'h03;

  // Reset values of the two registers
  localparam logic [15:0] MODE_RESET        = 16'h0510;
  localparam logic [15:0] CLOCK_RESET       = 16'h0f0e;

  // Writable bits of the clock register; the top nibble is read-only zero
  localparam logic [15:0] CLOCK_WRITE_MASK  = 16'h0fff;

  // Mode register field positions
  localparam int          MODE_REGMAP_CHECK = 13;
  localparam int          MODE_INPUT_CHECK  = 12;
  localparam int          MODE_CHECK_POLY   = 11;
  localparam int          MODE_RESET_FLAG   = 10;
  localparam int          MODE_WLEN_HI      = 9;
  localparam int          MODE_WLEN_LO      = 8;
  localparam int          MODE_TIMEOUT      = 4;
  localparam int          MODE_RSRC_HI      = 3;
  localparam int          MODE_RSRC_LO      = 2;
  localparam int          MODE_IDLE_FLOAT   = 1;
  localparam int          MODE_PULSE_FMT    = 0;

  // Clock register field positions
  localparam int          CLOCK_CHAN_HI     = 11;
  localparam int          CLOCK_CHAN_LO     = 8;
  localparam int          CLOCK_RATIO64     = 5;
  localparam int          CLOCK_RATIO_HI    = 4;
  localparam int          CLOCK_RATIO_LO    = 2;
  localparam int          CLOCK_POWER_HI    = 1;
  localparam int          CLOCK_POWER_LO    = 0;

  // Output word length encodings
  localparam logic [1:0]  WLEN_16           = 2'h0;
  localparam logic [1:0]  WLEN_24           = 2'h1;
  localparam logic [1:0]  WLEN_32_PAD       = 2'h2;
  localparam logic [1:0]  WLEN_32_SIGN      = 2'h3;

  // Ready source encodings; code 3 behaves as code 2
  localparam logic [1:0]  RSRC_LAGGING      = 2'h0;
  localparam logic [1:0]  RSRC_ANY          = 2'h1;

  // Power mode encodings; code 3 behaves as code 2
  localparam logic [1:0]  POWER_VERY_LOW    = 2'h0;
  localparam logic [1:0]  POWER_LOW         = 2'h1;

  // Forced oversampling ratio
  localparam logic [14:0] RATIO_FORCED      = 15'h0040;

  // Fixed ready low pulse, in ns and in cycles of the 8 ns clock
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          READY_PULSE_NS    = 32;
  localparam int          READY_PULSE_CYC   = (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  READY_PULSE_LEN   = 4'(READY_PULSE_CYC);

  // Pin drive phases of the ready output
  typedef enum logic [1:0] {
    PIN_IDLE,
    PIN_LOW_LEVEL,
    PIN_LOW_PULSE
  } pin_phase_type;

endpackage

`default_nettype wire

// ---- bench/adc_mode_clock_config_monitor.sv ----
/*
  Concurrent checks on the mode/clock configuration block's ports.
  Assumes one clock, sys_clk, and a synchronous active-high rst.
*/
`timescale 1ns/100ps
`default_nettype none

module adc_mode_clock_config_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [5:0]  reg_index,
  input wire logic        reg_write,
  input wire logic [15:0] reg_write_data,
  input wire logic [15:0] reg_read_data,
  input wire logic        rx_check_fail,
  input wire logic        rx_check_enable,
  input wire logic [1:0]  word_length_select,
  input wire logic        frame_timeout_enable,
  input wire logic [1:0]  ready_source_select,
  input wire logic        ready_idle_float,
  input wire logic        ready_pulse_format,
  input wire logic        chan0_conv_enable,
  input wire logic        chan1_conv_enable,
  input wire logic        chan2_conv_enable,
  input wire logic        chan3_conv_enable,
  input wire logic        ratio64_override,
  input wire logic [2:0]  oversample_ratio_select,
  input wire logic [14:0] oversample_ratio,
  input wire logic        status_reset_flag,
  input wire logic        status_check_error,
  input wire logic        data_ready_pin_out,
  input wire logic        data_ready_pin_oe
);
  // One domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_clock_top_zero; $past(reg_index) == 6'h03 |-> reg_read_data[15:12] == 4'h0; endproperty
  a_clock_top_zero: assert property (p_clock_top_zero) else $error("clock top nibble not zero");
  property p_chan_write; reg_write && reg_index == 6'h03 |=> {chan3_conv_enable, chan2_conv_enable,
    chan1_conv_enable, chan0_conv_enable} == $past(reg_write_data[11:8]); endproperty
  a_chan_write: assert property (p_chan_write) else $error("channel enables not stored");
  property p_ratio_forced; ratio64_override |=> oversample_ratio == 15'h0040; endproperty
  a_ratio_forced: assert property (p_ratio_forced) else $error("ratio not forced");
  // Code 7 is not a power of two, so it is decoded apart
  property p_ratio_field; !ratio64_override |=> oversample_ratio == (($past(oversample_ratio_select) == 3'h7) ?
    15'h3f80 : (15'h0080 << $past(oversample_ratio_select))); endproperty
  a_ratio_field: assert property (p_ratio_field) else $error("ratio decode wrong");
  property p_mode_write; reg_write && reg_index == 6'h02 |=> {word_length_select, frame_timeout_enable,
    ready_source_select, ready_idle_float, ready_pulse_format} == {$past(reg_write_data[9:8]),
    $past(reg_write_data[4:0])}; endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode fields not stored");
  property p_flag_clear; reg_write && reg_index == 6'h02 && !reg_write_data[10] |=> !status_reset_flag; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("reset flag not cleared");
  property p_flag_hold; status_reset_flag && !(reg_write && reg_index == 6'h02) |=> status_reset_flag; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("reset flag lost");
  property p_check_error; rx_check_fail && rx_check_enable |=> status_check_error; endproperty
  a_check_error: assert property (p_check_error) else $error("check error not set");
  property p_float_only; !data_ready_pin_oe |-> $past(ready_idle_float); endproperty
  a_float_only: assert property (p_float_only) else $error("pin released while not floating");
  property p_pulse_len; $fell(data_ready_pin_out) && ready_pulse_format |-> !data_ready_pin_out [*4] ##1
    data_ready_pin_out; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("ready pulse length wrong");
endmodule

bind adc_mode_clock_config adc_mode_clock_config_monitor u_adc_mode_clock_config_monitor (.*);

`default_nettype wire

// ---- bench/host_port_model.sv ----
/*
  Host side of the register word port: writes and reads whole words.
  Assumes requests are launched just after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module host_port_model (
  input  wire logic        sys_clk,
  output logic      [5:0]  reg_index,
  output logic             reg_write,
  output logic      [15:0] reg_write_data,
  input  wire logic [15:0] reg_read_data
);
  // Quiet port until the first request
  initial begin
    reg_index = 6'h00;
    reg_write = 1'b0;
    reg_write_data = 16'h0000;
  end

  // Reserved bits go out as zero unless a refusal is being provoked
  task automatic write_word(input logic [5:0] idx, input logic [15:0] d, input bit raw);
    @(posedge sys_clk);
    reg_index <= idx;
    reg_write <= 1'b1;
    reg_write_data <= raw ? d : d & ((idx == 6'h03) ? 16'h0f3f : 16'h3f1f);
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_write_data <= ~d; // Junk once released, never the last word
  endtask

  // Read word is registered one edge after the index appears
  task automatic read_word(input logic [5:0] idx, output logic [15:0] d);
    @(posedge sys_clk);
    reg_index <= idx;
    @(posedge sys_clk);
    #1;
    d = reg_read_data;
  endtask
endmodule

`default_nettype wire

// ---- bench/test_adc_mode_clock_config.sv ----
/*
  Self-checking bench for the mode/clock configuration block.
  Assumes the host model drives the word port; events come from here.
*/
`timescale 1ns/100ps
`default_nettype none

module test_adc_mode_clock_config;
  logic sys_clk, rst, reg_write, rx_check_fail, status_read, data_frame_read;
  logic [5:0] reg_index;
  logic [15:0] reg_write_data, reg_read_data, rd;
  logic [3:0] chan_new_data, chan_pending;
  logic regmap_check_enable, rx_check_enable, check_poly_ansi, frame_timeout_enable, ready_idle_float;
  logic ready_pulse_format, chan0_conv_enable, chan1_conv_enable, chan2_conv_enable, chan3_conv_enable;
  logic ratio64_override, power_very_low, power_low, status_reset_flag, status_check_error;
  logic data_ready_pin_out, data_ready_pin_oe;
  logic [1:0] word_length_select, ready_source_select, power_mode_select;
  logic [2:0] oversample_ratio_select;
  logic [14:0] oversample_ratio;
  int err_count, cmp_count, cycles;

  adc_mode_clock_config u_adc_mode_clock_config (.*);
  host_port_model u_host_port_model (.*);

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input bit raw = 1'b0);
    u_host_port_model.write_word(i, d, raw);
  endtask
  // One-cycle event pulses, released at the following edge
  task automatic ev(input logic [3:0] ch, input logic frd, input logic fail, input logic srd);
    @(posedge sys_clk);
    {chan_new_data, data_frame_read, rx_check_fail, status_read} <= {ch, frd, fail, srd};
    @(posedge sys_clk);
    {chan_new_data, data_frame_read, rx_check_fail, status_read} <= 7'h00;
  endtask
  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset();
    u_host_port_model.read_word(6'h02, rd);
    chk("mode", 16'h0510, rd);
    u_host_port_model.read_word(6'h03, rd);
    chk("clock", 16'h0f0e, rd);
    chk("flags", 16'h000b, {12'h000, status_reset_flag, status_check_error, data_ready_pin_out,
      data_ready_pin_oe});
    chk("ratio", 16'h0400, {1'b0, oversample_ratio});
  endtask
  task automatic t_mode();
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {2'b00, i[0], i[1], i[0], 1'b1, i[1:0], 3'b000, i[0], i[1:0], 2'b00};
      wr(6'h02, d);
      u_host_port_model.read_word(6'h02, rd);
      chk("mode back", d, rd);
      chk("mode out", {2'b00, d[13:11], 1'b0, d[9:8], 3'b000, d[4:0]},
        {2'b00, regmap_check_enable, rx_check_enable, check_poly_ansi, 1'b0, word_length_select, 3'b000,
        frame_timeout_enable, ready_source_select, ready_idle_float, ready_pulse_format});
    end
  endtask
  task automatic t_clock();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {4'hf, 4'ha, 3'b000, i[2:0], i[1:0]};
      wr(6'h03, d, 1'b1);
      u_host_port_model.read_word(6'h03, rd);
      chk("clock back", {4'h0, d[11:0]}, rd);
      chk("ratio", (i == 7) ? 16'h3f80 : 16'h0080 << i, {1'b0, oversample_ratio});
      chk("clock out", {4'h0, d[11:8], 1'b0, d[4:0], i[1:0] == 2'h0, i[1:0] == 2'h1},
        {4'h0, chan3_conv_enable, chan2_conv_enable, chan1_conv_enable, chan0_conv_enable, ratio64_override,
        oversample_ratio_select, power_mode_select, power_very_low, power_low});
    end
    wr(6'h03, 16'h0f2e);
    settle();
    chk("forced", 16'h0040, {1'b0, oversample_ratio});
    wr(6'h03, 16'h0f0e);
  endtask
  task automatic t_flags();
    wr(6'h02, 16'h0510);
    ev(4'h0, 1'b0, 1'b1, 1'b0);
    #1;
    chk("err off", 16'h0000, {15'h0, status_check_error});
    wr(6'h02, 16'h1510);
    ev(4'h0, 1'b0, 1'b1, 1'b0);
    #1;
    chk("err on", 16'h0001, {15'h0, status_check_error});
    ev(4'h0, 1'b0, 1'b0, 1'b1);
    #1;
    chk("err clr", 16'h0001, {15'h0, !status_check_error & status_reset_flag});
    wr(6'h02, 16'h0110);
    #1;
    chk("flag clr", 16'h0000, {15'h0, status_reset_flag});
    // A second reset in mid-run must bring the flag and the mode word back
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    u_host_port_model.read_word(6'h02, rd);
    chk("mode rst", 16'h0510, rd);
    chk("flag rst", 16'h0001, {15'h0, status_reset_flag});
  endtask
  // Level format with any-channel source, then all-channels with two enabled,
  // then the leading source
  task automatic t_ready();
    wr(6'h02, 16'h0104);
    ev(4'h1, 1'b0, 1'b0, 1'b0);
    settle();
    chk("any low", 16'h0000, {15'h0, data_ready_pin_out});
    ev(4'h0, 1'b1, 1'b0, 1'b0);
    settle();
    chk("any idle", 16'h0001, {15'h0, data_ready_pin_out});
    wr(6'h03, 16'h030e);
    wr(6'h02, 16'h0100);
    ev(4'hd, 1'b0, 1'b0, 1'b0);
    settle();
    chk("lag wait", 16'h0001, {15'h0, data_ready_pin_out});
    chk("pend mask", 16'h0001, {12'h000, chan_pending});
    ev(4'h2, 1'b0, 1'b0, 1'b0);
    settle();
    chk("lag low", 16'h0000, {15'h0, data_ready_pin_out});
    ev(4'h0, 1'b1, 1'b0, 1'b0);
    wr(6'h02, 16'h0108);
    ev(4'h2, 1'b0, 1'b0, 1'b0);
    settle();
    chk("lead low", 16'h0000, {15'h0, data_ready_pin_out});
    chk("lead pend", 16'h0002, {12'h000, chan_pending});
    ev(4'h0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_pulse();
    wr(6'h03, 16'h0f0e);
    wr(6'h02, 16'h0107);
    settle();
    chk("float", 16'h0000, {15'h0, data_ready_pin_oe});
    ev(4'h4, 1'b0, 1'b0, 1'b0);
    settle();
    chk("pulse", 16'h0001, {14'h0, data_ready_pin_out, data_ready_pin_oe});
    repeat (3) @(posedge sys_clk);
    #1;
    chk("pulse held", 16'h0001, {14'h0, data_ready_pin_out, data_ready_pin_oe});
    settle();
    chk("pulse end", 16'h0000, {15'h0, data_ready_pin_oe});
    ev(4'h0, 1'b1, 1'b0, 1'b0);
  endtask

  // Cut a hang short; the run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {chan_new_data, data_frame_read, rx_check_fail, status_read} = 7'h00;
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_clock();
    t_flags();
    t_ready();
    t_pulse();
    summarize();
  end
endmodule

`default_nettype wire
